// *** core/txtio_pkg.sv ***
// Constants shared by the transmit test and interrupt output block.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
package txtio_pkg;
  localparam logic [7:0] OFS_STATUS = 8'h60;
  localparam logic [7:0] OFS_CLEAR = 8'h64;
  localparam logic [7:0] OFS_ENABLE = 8'h68;
  localparam logic [7:0] OFS_TEST = 8'hd0;
  localparam logic [7:0] OFS_PAT_A = 8'hd4;
  localparam logic [7:0] OFS_PAT_B = 8'hd8;
  localparam logic [7:0] OFS_PAT_C = 8'hdc;
  localparam logic [7:0] OFS_PAT_D = 8'he0;
  localparam int EVT_W = 3;
  localparam int EVT_SYNC_REQ = 0;
  localparam int EVT_SYNC_ERR = 1;
  localparam int EVT_FRAME_ERR = 2;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 4;
  localparam logic [31:0] RST_PATTERN = 32'h0000_0000;
  localparam logic [3:0] RST_MODE = 4'h0;
  localparam logic [EVT_W-1:0] RST_ENABLE = 3'h7;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// *** core/txtio_sync2.sv ***
// Two-flop synchroniser for a group of level inputs.
// Assumes the inputs come from outside the CLK domain.
`timescale 1ns/100ps
`default_nettype none
module txtio_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** core/txtio_evt.sv ***
// Sticky event status with clear, enable and a level interrupt.
// Assumes event pulses arrive synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module txtio_evt #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] evt,
  input wire logic [W-1:0] clr,
  input wire logic [W-1:0] en,
  output logic [W-1:0] status_q,
  output logic irq_q
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clr) | evt;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((status_q & ~clr) | evt) & en);
    end
  end
endmodule
`default_nettype wire

// *** core/txtio_top.sv ***
// Transmit test pattern, test mode, loopback and interrupt outputs.
// Assumes an Avalon-MM master on CLK and link event pins from outside.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module txtio_top #(
  parameter int LANES = 2
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic SYNC_REQ_N,
  input wire logic SYNC_ERR,
  input wire logic FRAME_ERR,
  input wire logic [LANES*32-1:0] LINK_DATA,
  input wire logic [LANES*4-1:0] LINK_CTRL_FLAGS,
  output logic TX_IRQ_OUT,
  output logic [3:0] TEST_MODE,
  output logic [31:0] PATTERN_A,
  output logic [31:0] PATTERN_B,
  output logic [31:0] PATTERN_C,
  output logic [31:0] PATTERN_D,
  output logic [LANES*32-1:0] LOOPBACK_LANE_DATA,
  output logic [LANES*4-1:0] LOOPBACK_CTRL_CHAR_FLAGS
);
  localparam int EW = txtio_pkg::EVT_W;

  typedef enum logic [1:0] {
    TXTIO_IDLE = 2'b00,
    TXTIO_ACK = 2'b01
  } txtio_bus_e;

  txtio_bus_e state_q;
  logic [2:0] pins_s;
  logic sync_req_q;
  logic sync_err_q;
  logic frame_err_q;
  logic [EW-1:0] evt;
  logic [EW-1:0] clr_q;
  logic [EW-1:0] en_q;
  logic [EW-1:0] status;
  logic irq;
  logic [31:0] pat_q [4];
  logic [31:0] rd_d;
  logic wr_take;
  logic rd_take;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic int pat_index(input logic [7:0] a);
    int r;
    r = -1;
    case (a)
      txtio_pkg::OFS_PAT_A: r = 0;
      txtio_pkg::OFS_PAT_B: r = 1;
      txtio_pkg::OFS_PAT_C: r = 2;
      txtio_pkg::OFS_PAT_D: r = 3;
      default: r = -1;
    endcase
    return r;
  endfunction

  txtio_sync2 #(.W(3)) u_sync (
    .clk(CLK),
    .rst(RST),
    .d({FRAME_ERR, SYNC_ERR, ~SYNC_REQ_N}),
    .q(pins_s)
  );

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync_req_q <= 1'b0;
      sync_err_q <= 1'b0;
      frame_err_q <= 1'b0;
    end else begin
      sync_req_q <= pins_s[0];
      sync_err_q <= pins_s[1];
      frame_err_q <= pins_s[2];
    end
  end

  always_comb begin
    evt = '0;
    evt[txtio_pkg::EVT_SYNC_REQ] = pins_s[0] & ~sync_req_q;
    evt[txtio_pkg::EVT_SYNC_ERR] = pins_s[1] & ~sync_err_q;
    evt[txtio_pkg::EVT_FRAME_ERR] = pins_s[2] & ~frame_err_q;
  end

  txtio_evt #(.W(EW)) u_evt (
    .clk(CLK),
    .rst(RST),
    .evt(evt),
    .clr(clr_q),
    .en(en_q),
    .status_q(status),
    .irq_q(irq)
  );

  assign wr_take = AVS_WRITE && (state_q == TXTIO_IDLE);
  assign rd_take = AVS_READ && (state_q == TXTIO_IDLE);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= TXTIO_IDLE;
    end else begin
      case (state_q)
        TXTIO_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            state_q <= TXTIO_ACK;
          end
        end
        TXTIO_ACK: state_q <= TXTIO_IDLE;
        default: state_q <= TXTIO_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && state_q == TXTIO_IDLE);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      clr_q <= '0;
    end else if (wr_take && AVS_ADDRESS == txtio_pkg::OFS_CLEAR && AVS_BYTEENABLE[0]) begin
      clr_q <= AVS_WRITEDATA[EW-1:0];
    end else begin
      clr_q <= '0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      en_q <= txtio_pkg::RST_ENABLE;
    end else if (wr_take && AVS_ADDRESS == txtio_pkg::OFS_ENABLE && AVS_BYTEENABLE[0]) begin
      en_q <= AVS_WRITEDATA[EW-1:0];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      TEST_MODE <= txtio_pkg::RST_MODE;
    end else if (wr_take && AVS_ADDRESS == txtio_pkg::OFS_TEST && AVS_BYTEENABLE[0]) begin
      TEST_MODE <= AVS_WRITEDATA[txtio_pkg::MODE_LSB +: txtio_pkg::MODE_W];
    end
  end

  generate
    for (genvar g = 0; g < 4; g++) begin : g_pat
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          pat_q[g] <= txtio_pkg::RST_PATTERN;
        end else if (wr_take && pat_index(AVS_ADDRESS) == g) begin
          pat_q[g] <= merge(pat_q[g], AVS_WRITEDATA, AVS_BYTEENABLE);
        end
      end
    end
  endgenerate

  assign PATTERN_A = pat_q[0];
  assign PATTERN_B = pat_q[1];
  assign PATTERN_C = pat_q[2];
  assign PATTERN_D = pat_q[3];

  always_comb begin
    rd_d = txtio_pkg::RD_UNMAPPED;
    case (AVS_ADDRESS)
      txtio_pkg::OFS_STATUS: rd_d = {{(32-EW){1'b0}}, status};
      txtio_pkg::OFS_ENABLE: rd_d = {{(32-EW){1'b0}}, en_q};
      txtio_pkg::OFS_TEST: rd_d = {28'h0000000, TEST_MODE};
      txtio_pkg::OFS_PAT_A: rd_d = pat_q[0];
      txtio_pkg::OFS_PAT_B: rd_d = pat_q[1];
      txtio_pkg::OFS_PAT_C: rd_d = pat_q[2];
      txtio_pkg::OFS_PAT_D: rd_d = pat_q[3];
      default: rd_d = txtio_pkg::RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (rd_take) begin
      AVS_READDATA <= rd_d;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      TX_IRQ_OUT <= 1'b0;
      LOOPBACK_LANE_DATA <= '0;
      LOOPBACK_CTRL_CHAR_FLAGS <= '0;
    end else begin
      TX_IRQ_OUT <= irq;
      LOOPBACK_LANE_DATA <= LINK_DATA;
      LOOPBACK_CTRL_CHAR_FLAGS <= LINK_CTRL_FLAGS;
    end
  end

  property p_pat_write;
    @(posedge CLK) disable iff (RST)
      (wr_take && AVS_ADDRESS == txtio_pkg::OFS_PAT_A && AVS_BYTEENABLE == 4'hf)
      |=> PATTERN_A == $past(AVS_WRITEDATA);
  endproperty
  a_pat_write: assert property (p_pat_write) else $error("pattern A not updated");

  property p_pat_d_write;
    @(posedge CLK) disable iff (RST)
      (wr_take && AVS_ADDRESS == txtio_pkg::OFS_PAT_D && AVS_BYTEENABLE == 4'hf)
      |=> PATTERN_D == $past(AVS_WRITEDATA);
  endproperty
  a_pat_d_write: assert property (p_pat_d_write) else $error("pattern D not updated");

  property p_pat_hold;
    @(posedge CLK) disable iff (RST)
      !(wr_take && pat_index(AVS_ADDRESS) == 1) |=> $stable(PATTERN_B);
  endproperty
  a_pat_hold: assert property (p_pat_hold) else $error("pattern B changed without write");

  property p_mode;
    @(posedge CLK) disable iff (RST)
      (wr_take && AVS_ADDRESS == txtio_pkg::OFS_TEST && AVS_BYTEENABLE[0])
      |=> TEST_MODE == $past(AVS_WRITEDATA[3:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("test mode not mirrored");

  sequence s_enabled_pending;
    (status & en_q) != '0 && clr_q == '0;
  endsequence
  property p_irq_on;
    @(posedge CLK) disable iff (RST) s_enabled_pending |=> ##1 TX_IRQ_OUT;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

  property p_irq_masked;
    @(posedge CLK) disable iff (RST)
      ((status & en_q) == '0 && evt == '0 && clr_q == '0) ##1 (evt == '0) |=> !TX_IRQ_OUT;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt without enabled event");

  property p_evt_sticky;
    @(posedge CLK) disable iff (RST)
      evt[txtio_pkg::EVT_SYNC_REQ] |=> status[txtio_pkg::EVT_SYNC_REQ];
  endproperty
  a_evt_sticky: assert property (p_evt_sticky) else $error("sync request not latched");

  property p_loop;
    @(posedge CLK) disable iff (RST)
      1'b1 |=> LOOPBACK_LANE_DATA == $past(LINK_DATA)
        && LOOPBACK_CTRL_CHAR_FLAGS == $past(LINK_CTRL_FLAGS);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback data mismatch");

  sequence s_bus_take;
    (AVS_READ || AVS_WRITE) && state_q == TXTIO_IDLE;
  endsequence
  sequence s_bus_answer;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  property p_wait_ack;
    @(posedge CLK) disable iff (RST) s_bus_take |=> s_bus_answer;
  endproperty
  a_wait_ack: assert property (p_wait_ack) else $error("waitrequest not low for one cycle");

  property p_wait_idle;
    @(posedge CLK) disable iff (RST)
      !((AVS_READ || AVS_WRITE) && state_q == TXTIO_IDLE) |=> AVS_WAITREQUEST;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low without request");

  property p_pat_b_write;
    @(posedge CLK) disable iff (RST)
      (wr_take && AVS_ADDRESS == txtio_pkg::OFS_PAT_B && AVS_BYTEENABLE == 4'hf)
      |=> PATTERN_B == $past(AVS_WRITEDATA);
  endproperty
  a_pat_b_write: assert property (p_pat_b_write) else $error("pattern B not updated");

  property p_pat_c_write;
    @(posedge CLK) disable iff (RST)
      (wr_take && AVS_ADDRESS == txtio_pkg::OFS_PAT_C && AVS_BYTEENABLE == 4'hf)
      |=> PATTERN_C == $past(AVS_WRITEDATA);
  endproperty
  a_pat_c_write: assert property (p_pat_c_write) else $error("pattern C not updated");

  property p_pat_a_hold;
    @(posedge CLK) disable iff (RST)
      !(wr_take && pat_index(AVS_ADDRESS) == 0) |=> $stable(PATTERN_A);
  endproperty
  a_pat_a_hold: assert property (p_pat_a_hold) else $error("pattern A changed without write");

  property p_mode_hold;
    @(posedge CLK) disable iff (RST)
      !(wr_take && AVS_ADDRESS == txtio_pkg::OFS_TEST && AVS_BYTEENABLE[0]) |=> $stable(TEST_MODE);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("test mode changed without write");

  property p_rd_pat_c;
    @(posedge CLK) disable iff (RST)
      (rd_take && AVS_ADDRESS == txtio_pkg::OFS_PAT_C)
      |=> AVS_READDATA == $past(PATTERN_C);
  endproperty
  a_rd_pat_c: assert property (p_rd_pat_c) else $error("pattern C read back wrong");

  property p_rd_mode;
    @(posedge CLK) disable iff (RST)
      (rd_take && AVS_ADDRESS == txtio_pkg::OFS_TEST)
      |=> AVS_READDATA == {28'h0000000, $past(TEST_MODE)};
  endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("test mode read back wrong");

  property p_en_write;
    @(posedge CLK) disable iff (RST)
      (wr_take && AVS_ADDRESS == txtio_pkg::OFS_ENABLE && AVS_BYTEENABLE[0])
      |=> en_q == $past(AVS_WRITEDATA[EW-1:0]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable not written");

  property p_set_wins;
    @(posedge CLK) disable iff (RST)
      evt != '0 |=> (status & $past(evt)) == $past(evt);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

  property p_clear_drop;
    @(posedge CLK) disable iff (RST)
      (clr_q != '0 && evt == '0) |=> (status & $past(clr_q)) == '0;
  endproperty
  a_clear_drop: assert property (p_clear_drop) else $error("status not cleared");
endmodule
`default_nettype wire

// *** testbench/txtio_far.sv ***
// Far-side model: transmit link layer data feeding the loopback path.
// Assumes it shares CLK and RST with the block under test.
`timescale 1ns/100ps
`default_nettype none
module txtio_far #(
  parameter int LANES = 2
) (
  input wire logic clk,
  input wire logic rst,
  output logic [LANES*32-1:0] data,
  output logic [LANES*4-1:0] flags
);
  // Data and flags change on every cycle so a stale copy is caught.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data <= '0;
      flags <= '0;
    end else begin
      data <= {data[LANES*32-2:0], ~data[LANES*32-1]};
      flags <= flags + 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the transmit test and interrupt outputs.
// Assumes txtio_pkg, txtio_top and txtio_far are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  localparam int LANES = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hf;
  logic [2:0] ev = 3'h0;
  logic [31:0] rdat, rv;
  logic [31:0] pat [4];
  logic wreq, irq;
  logic [3:0] mode;
  logic [LANES*32-1:0] ld, lbd;
  logic [LANES*4-1:0] lf, lbf;
  int error_cnt = 0;
  int n_tests = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  txtio_far #(.LANES(LANES)) far (.clk(clk), .rst(rst), .data(ld), .flags(lf));
  txtio_top #(.LANES(LANES)) DUT (
    .CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
    .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .SYNC_REQ_N(~ev[0]),
    .SYNC_ERR(ev[1]), .FRAME_ERR(ev[2]), .LINK_DATA(ld),
    .LINK_CTRL_FLAGS(lf), .TX_IRQ_OUT(irq), .TEST_MODE(mode),
    .PATTERN_A(pat[0]), .PATTERN_B(pat[1]), .PATTERN_C(pat[2]),
    .PATTERN_D(pat[3]), .LOOPBACK_LANE_DATA(lbd),
    .LOOPBACK_CTRL_CHAR_FLAGS(lbf));
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    adr <= a;
    wdat <= d;
    be <= b;
    wr_en <= 1'b1;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    adr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    rv = rdat;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    repeat (8) @(posedge clk);
    ev[i] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_rst;
    `CHK(irq, 1'b0)
    `CHK(mode, txtio_pkg::RST_MODE)
    for (int k = 0; k < 4; k++) `CHK(pat[k], txtio_pkg::RST_PATTERN)
    rd(txtio_pkg::OFS_ENABLE);
    `CHK(rv[2:0], txtio_pkg::RST_ENABLE)
    $display("test reset done");
  endtask
  task automatic t_rst2;
    wr(txtio_pkg::OFS_PAT_B, 32'h5a5a_a5a5, 4'hf);
    wr(txtio_pkg::OFS_TEST, 32'h9, 4'hf);
    wr(txtio_pkg::OFS_ENABLE, 32'h4, 4'hf);
    pulse(2);
    `CHK(irq, 1'b1)
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(wreq, 1'b1)
    `CHK(irq, 1'b0)
    `CHK(mode, txtio_pkg::RST_MODE)
    `CHK(pat[1], txtio_pkg::RST_PATTERN)
    rst <= 1'b0;
    @(posedge clk);
    rd(txtio_pkg::OFS_ENABLE);
    `CHK(rv[2:0], txtio_pkg::RST_ENABLE)
    rd(txtio_pkg::OFS_STATUS);
    `CHK(rv, 32'h0)
    $display("test mid reset done");
  endtask
  task automatic t_pat;
    logic [31:0] v [4];
    for (int k = 0; k < 4; k++) begin
      v[k] = 32'hc35a_0f00 + 32'(k + 1);
      wr(txtio_pkg::OFS_PAT_A + 8'(4 * k), v[k], 4'hf);
      for (int j = 0; j < 4; j++) `CHK(pat[j], (j <= k) ? v[j] : 32'h0)
    end
    for (int k = 0; k < 4; k++) begin
      rd(txtio_pkg::OFS_PAT_A + 8'(4 * k));
      `CHK(rv, v[k])
    end
    wr(txtio_pkg::OFS_PAT_A, 32'hffff_ffff, 4'h6);
    `CHK(pat[0], {v[0][31:24], 16'hffff, v[0][7:0]})
    wr(8'hf4, 32'h0, 4'hf);
    `CHK(pat[3], v[3])
    rd(8'h10);
    `CHK(rv, txtio_pkg::RD_UNMAPPED)
    rd(txtio_pkg::OFS_CLEAR);
    `CHK(rv, txtio_pkg::RD_UNMAPPED)
    $display("test patterns done");
  endtask
  task automatic t_mode;
    for (int m = 0; m < 16; m += 5) begin
      wr(txtio_pkg::OFS_TEST, 32'(m), 4'hf);
      `CHK(mode, 4'(m))
      rd(txtio_pkg::OFS_TEST);
      `CHK(rv, 32'(m))
    end
    $display("test mode done");
  endtask
  task automatic t_irq;
    for (int i = 0; i < 3; i++) begin
      wr(txtio_pkg::OFS_ENABLE, 32'h7 & ~(32'h1 << i), 4'hf);
      pulse(i);
      `CHK(irq, 1'b0)
      rd(txtio_pkg::OFS_STATUS);
      `CHK(rv, 32'h1 << i)
      wr(txtio_pkg::OFS_STATUS, 32'h0, 4'hf);
      rd(txtio_pkg::OFS_STATUS);
      `CHK(rv, 32'h1 << i)
      wr(txtio_pkg::OFS_ENABLE, 32'h7, 4'hf);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      wr(txtio_pkg::OFS_CLEAR, 32'h1 << i, 4'hf);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      pulse(i);
      `CHK(irq, 1'b1)
      wr(txtio_pkg::OFS_CLEAR, 32'h7, 4'hf);
      repeat (2) @(posedge clk);
      rd(txtio_pkg::OFS_STATUS);
      `CHK(rv, 32'h0)
    end
    $display("test interrupt done");
  endtask
  task automatic t_lb;
    logic [LANES*32-1:0] pd;
    logic [LANES*4-1:0] pf;
    @(posedge clk);
    pd = ld;
    pf = lf;
    repeat (8) begin
      @(posedge clk);
      `CHK(lbd, pd)
      `CHK(lbf, pf)
      pd = ld;
      pf = lf;
    end
    $display("test loopback done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    `CHK(wreq, 1'b1)
    rst <= 1'b0;
    @(posedge clk);
    t_rst();
    t_pat();
    t_mode();
    t_irq();
    t_lb();
    t_rst2();
    results();
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
